/* rtl/mcl_pkg.sv */
// Package: register map, field positions and constants for the main configuration register block
package mcl_pkg;
    localparam int          MCL_DATA_W         = 32;
    localparam int          MCL_ADDR_W         = 8;
    // Register byte addresses
    localparam logic [7:0]  MCL_CFG_OFF        = 8'h00;
    localparam logic [7:0]  MCL_IRQ_STAT_OFF   = 8'h04;
    localparam logic [7:0]  MCL_IRQ_MASK_OFF   = 8'h08;
    localparam logic [7:0]  MCL_DEFER_CNT_OFF  = 8'h0C;
    localparam logic [7:0]  MCL_STATUS_OFF     = 8'h10;
    // Configuration bit positions
    localparam int          MCL_BIT_BIG_ENDIAN = 0;
    localparam int          MCL_BIT_RSVD1      = 1;
    localparam int          MCL_BIT_BOOT_ROM_DISABLE   = 2;
    localparam int          MCL_BIT_PAR_ACT    = 3;
    localparam int          MCL_BIT_DEFER_DIS  = 4;
    localparam int          MCL_BIT_WIN_SEL    = 5;
    localparam int          MCL_BIT_SINGLE_BO  = 6;
    localparam int          MCL_BIT_REQ_POL    = 7;
    localparam int          MCL_BIT_LEGACY     = 8;
    localparam int          MCL_BIT_INTERNAL_PHY_DISABLE    = 9;
    localparam int          MCL_BIT_PHY_RST    = 10;
    localparam int          MCL_BIT_EXTERNAL_PHY_SELECT    = 12;
    localparam logic [31:0] MCL_CFG_WMASK      = 32'h0000_17FD;
    localparam logic [31:0] MCL_CFG_RESET      = 32'h0000_0000;
    // Interrupt status bit positions
    localparam int          MCL_IRQ_PARITY     = 0;
    localparam int          MCL_IRQ_DEFER      = 1;
    localparam int          MCL_IRQ_W          = 2;
    localparam logic [1:0]  MCL_IRQ_RESET      = 2'h0;
    // Descriptor word counts
    localparam logic [2:0]  MCL_DESC_WORDS_LEG = 3'h4;
    localparam logic [2:0]  MCL_DESC_WORDS_NEW = 3'h3;
    localparam logic [1:0]  MCL_FRAG_WORD_IDX  = 2'h2;
    localparam int          MCL_SLOT_BITS      = 512;
    localparam int          MCL_CNT_W          = 16;
endpackage

/* rtl/mcl_cfg_if.sv */
// Interface: configuration fields passed from the register file to the steering logic
`timescale 1ns/1ps
interface mcl_cfg_if;
    logic phy_reset;
    logic internal_phy_disable;
    logic legacy_descriptor_compat;
    logic bus_request_policy;
    logic single_backoff;
    logic window_timer_select;
    logic deferral_timer_disable;
    logic parity_action_select;
    logic boot_rom_disable;
    logic big_endian_master;
    logic external_phy_select;
    modport regs  (output phy_reset, internal_phy_disable, legacy_descriptor_compat, bus_request_policy,
                   single_backoff, window_timer_select, deferral_timer_disable, parity_action_select,
                   boot_rom_disable, big_endian_master, external_phy_select);
    modport steer (input  phy_reset, internal_phy_disable, legacy_descriptor_compat, bus_request_policy,
                   single_backoff, window_timer_select, deferral_timer_disable, parity_action_select,
                   boot_rom_disable, big_endian_master, external_phy_select);
endinterface : mcl_cfg_if

/* rtl/mcl_swap.sv */
// Byte order converter for bus-master data moves
`timescale 1ns/1ps
module mcl_swap
    import mcl_pkg::*;
(
    input  wire logic                  big_endian,
    input  wire logic [MCL_DATA_W-1:0] data_in,
    output logic      [MCL_DATA_W-1:0] data_out
);
    wire logic [MCL_DATA_W-1:0] swapped;
    assign swapped  = {data_in[7:0], data_in[15:8], data_in[23:16], data_in[31:24]};
    assign data_out = big_endian ? swapped : data_in;
endmodule // mcl_swap

/* rtl/mcl_top.sv */
// Main configuration register (low control bits) with APB access and steering outputs
//
// Overview of operation
// - While the phy reset bit is set the internal phy is held in reset, and the bit stays set until software clears it.
// - When the internal phy disable bit is one the internal phy is forced to its low-power state.
// - With the legacy bit set a descriptor fetch reads four words and the fragment count field is ignored.
// - With the legacy bit clear a descriptor fetch reads three words and the third word is the fragment pointer.
// - The bus request policy bit selects aggressive requests at zero and conservative requests at one.
// - With single back-off set the transmitter backs off exactly one slot time, otherwise it uses random back-off.
// - With window timer select at zero the out-of-window timer starts its 512-bit slot count after the delimiter.
// - With window timer select at one the out-of-window timer starts at the first preamble bit.
// - With the deferral timer disabled no transmit error is reported for excessive deferral.
// - With the deferral timer disabled the deferral status flag stays clear and the deferral counter does not count.
// - A bus-master data parity error raises the system error unless the parity action bit is one.
// - When the boot ROM disable bit is one all boot ROM interface activity is stopped.
// - When the big endian bit is set bus-master data transfers use big-endian byte order.
// - The big endian bit never changes the byte order of register accesses.
// - Setting the external phy select bit enables the media independent interface and sets the phy disable bit.
`timescale 1ns/1ps
module mcl_top
    import mcl_pkg::*;
#(
    parameter int CNT_W = MCL_CNT_W
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [MCL_ADDR_W-1:0] paddr,
    input  wire logic [MCL_DATA_W-1:0] pwdata,
    output logic      [MCL_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Events from the neighbouring units
    input  wire logic                  master_parity_err,
    input  wire logic                  excess_deferral_evt,
    input  wire logic                  master_active,
    input  wire logic [MCL_DATA_W-1:0] master_data_in,
    input  wire logic                  rx_sfd_seen,
    input  wire logic                  rx_preamble_start,
    input  wire logic                  boot_rom_req,
    // Steering outputs
    output logic                       phy_reset_out,
    output logic                       phy_low_power,
    output logic                       mii_enable,
    output logic [2:0]                 desc_fetch_words,
    output logic                       desc_frag_count_ignore,
    output logic [1:0]                 desc_frag_ptr_word,
    output logic                       bus_req_conservative,
    output logic                       backoff_single_slot,
    output logic                       window_timer_start,
    output logic                       tx_deferral_error,
    output logic                       excessive_deferral_status,
    output logic [CNT_W-1:0]           deferral_overrun_counter,
    output logic                       serr_req,
    output logic                       boot_rom_enable,
    output logic                       boot_rom_grant,
    output logic [MCL_DATA_W-1:0]      master_data_out,
    output logic                       irq
);
    mcl_cfg_if cfg ();

    logic [MCL_DATA_W-1:0] cfg_q;
    logic [MCL_IRQ_W-1:0]  stat_q;
    logic [MCL_IRQ_W-1:0]  mask_q;
    logic [CNT_W-1:0]      defer_cnt_q;
    logic                  defer_flag_q;

    // APB decode: zero-wait, one access cycle
    wire logic                  acc;
    wire logic                  wr;
    wire logic                  rd;
    wire logic                  hit_cfg;
    wire logic                  hit_stat;
    wire logic                  hit_mask;
    wire logic                  hit_cnt;
    wire logic                  hit_sts;
    wire logic                  mapped;
    assign acc      = psel && penable;
    assign wr       = acc && pwrite;
    assign rd       = acc && !pwrite;
    assign hit_cfg  = (paddr == MCL_CFG_OFF);
    assign hit_stat = (paddr == MCL_IRQ_STAT_OFF);
    assign hit_mask = (paddr == MCL_IRQ_MASK_OFF);
    assign hit_cnt  = (paddr == MCL_DEFER_CNT_OFF);
    assign hit_sts  = (paddr == MCL_STATUS_OFF);
    assign mapped   = hit_cfg || hit_stat || hit_mask || hit_cnt || hit_sts;

    // Config write: external phy select forces the phy disable bit as well
    wire logic [MCL_DATA_W-1:0] cfg_wval;
    wire logic [MCL_DATA_W-1:0] cfg_d;
    assign cfg_wval = pwdata & MCL_CFG_WMASK;
    assign cfg_d    = cfg_wval | (MCL_DATA_W'(cfg_wval[MCL_BIT_EXTERNAL_PHY_SELECT]) << MCL_BIT_INTERNAL_PHY_DISABLE);

    // Field fan-out
    assign cfg.phy_reset                = cfg_q[MCL_BIT_PHY_RST];
    assign cfg.internal_phy_disable     = cfg_q[MCL_BIT_INTERNAL_PHY_DISABLE];
    assign cfg.legacy_descriptor_compat = cfg_q[MCL_BIT_LEGACY];
    assign cfg.bus_request_policy       = cfg_q[MCL_BIT_REQ_POL];
    assign cfg.single_backoff           = cfg_q[MCL_BIT_SINGLE_BO];
    assign cfg.window_timer_select      = cfg_q[MCL_BIT_WIN_SEL];
    assign cfg.deferral_timer_disable   = cfg_q[MCL_BIT_DEFER_DIS];
    assign cfg.parity_action_select     = cfg_q[MCL_BIT_PAR_ACT];
    assign cfg.boot_rom_disable         = cfg_q[MCL_BIT_BOOT_ROM_DISABLE];
    assign cfg.big_endian_master        = cfg_q[MCL_BIT_BIG_ENDIAN];
    assign cfg.external_phy_select      = cfg_q[MCL_BIT_EXTERNAL_PHY_SELECT];

    // Event qualification
    wire logic                  par_evt;
    wire logic                  defer_evt;
    wire logic [MCL_IRQ_W-1:0]  evt_vec;
    wire logic [MCL_IRQ_W-1:0]  stat_d;
    assign par_evt   = master_parity_err && master_active;
    assign defer_evt = excess_deferral_evt && !cfg.deferral_timer_disable;
    assign evt_vec   = {defer_evt, par_evt};
    // Set wins over a write-one clear in the same cycle
    assign stat_d    = (stat_q & ~((wr && hit_stat) ? pwdata[MCL_IRQ_W-1:0] : MCL_IRQ_RESET)) | evt_vec;

    // Descriptor format selection
    wire logic [2:0]            words_d;
    assign words_d = cfg.legacy_descriptor_compat ? MCL_DESC_WORDS_LEG : MCL_DESC_WORDS_NEW;

    // Out-of-window timer start point
    wire logic                  win_start_d;
    assign win_start_d = cfg.window_timer_select ? rx_preamble_start : rx_sfd_seen;

    // Bus-master data byte order; register reads never pass through here
    wire logic [MCL_DATA_W-1:0] swapped;
    mcl_swap u_swap (
        .big_endian (cfg.big_endian_master),
        .data_in    (master_data_in),
        .data_out   (swapped)
    );

    // Read mux, plain little-endian register view
    wire logic [MCL_DATA_W-1:0] rdata_d;
    wire logic [MCL_DATA_W-1:0] status_word;
    wire logic                  irq_d_w;
    assign irq_d_w = |(stat_d & mask_q);
    assign status_word = {{(MCL_DATA_W-3){1'b0}}, defer_flag_q, irq_d_w, cfg.phy_reset};
    assign rdata_d = hit_cfg  ? (cfg_q & MCL_CFG_WMASK) :
                     hit_stat ? MCL_DATA_W'(stat_q) :
                     hit_mask ? MCL_DATA_W'(mask_q) :
                     hit_cnt  ? MCL_DATA_W'(defer_cnt_q) :
                     hit_sts  ? status_word :
                     32'h0000_0000;

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= MCL_CFG_RESET;
        end else if (wr && hit_cfg) begin
            cfg_q <= cfg_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= MCL_IRQ_RESET;
        end else begin
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= MCL_IRQ_RESET;
        end else if (wr && hit_mask) begin
            mask_q <= pwdata[MCL_IRQ_W-1:0];
        end
    end

    // Deferral flag and counter stay idle while the timer is disabled
    // Saturates rather than wraps, so a long burst never reads back as a small count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            defer_cnt_q <= '0;
        end else if (defer_evt && defer_cnt_q != '1) begin
            defer_cnt_q <= defer_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            defer_flag_q <= 1'b0;
        end else if (defer_evt) begin
            defer_flag_q <= 1'b1;
        end else if (wr && hit_stat && pwdata[MCL_IRQ_DEFER]) begin
            defer_flag_q <= 1'b0;
        end
    end

    // APB outputs: no wait states, unmapped addresses answer with an error
    wire logic                  setup_ph;
    assign setup_ph = psel && !penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_ph;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_ph && !mapped;
        end
    end

    // Read data is captured in the setup cycle and held until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_ph && !pwrite) begin
            prdata <= rdata_d;
        end
    end

    // Registered steering outputs, one short process per pin so each reset value sits by its update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_reset_out <= 1'b0;
        end else begin
            phy_reset_out <= cfg.phy_reset;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_low_power <= 1'b0;
        end else begin
            phy_low_power <= cfg.internal_phy_disable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mii_enable <= 1'b0;
        end else begin
            mii_enable <= cfg.external_phy_select;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            desc_fetch_words <= MCL_DESC_WORDS_NEW;
        end else begin
            desc_fetch_words <= words_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            desc_frag_count_ignore <= 1'b0;
        end else begin
            desc_frag_count_ignore <= cfg.legacy_descriptor_compat;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            desc_frag_ptr_word <= MCL_FRAG_WORD_IDX;
        end else begin
            desc_frag_ptr_word <= MCL_FRAG_WORD_IDX;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_req_conservative <= 1'b0;
        end else begin
            bus_req_conservative <= cfg.bus_request_policy;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            backoff_single_slot <= 1'b0;
        end else begin
            backoff_single_slot <= cfg.single_backoff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window_timer_start <= 1'b0;
        end else begin
            window_timer_start <= win_start_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_deferral_error <= 1'b0;
        end else begin
            tx_deferral_error <= defer_evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serr_req <= 1'b0;
        end else begin
            serr_req <= par_evt && !cfg.parity_action_select;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_rom_enable <= 1'b0;
        end else begin
            boot_rom_enable <= !cfg.boot_rom_disable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_rom_grant <= 1'b0;
        end else begin
            boot_rom_grant <= boot_rom_req && !cfg.boot_rom_disable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_data_out <= '0;
        end else if (master_active) begin
            master_data_out <= swapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_d_w;
        end
    end

    assign excessive_deferral_status = defer_flag_q;
    assign deferral_overrun_counter  = defer_cnt_q;
endmodule // mcl_top

/* tb/mcl_top_monitor.sv */
// Checker for the configuration register block, bound to its top module
`timescale 1ns/1ps
module mcl_top_monitor
    import mcl_pkg::*;
#(
    parameter int CNT_W = MCL_CNT_W
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    input wire logic             master_parity_err,
    input wire logic             excess_deferral_evt,
    input wire logic             master_active,
    input wire logic [31:0]      master_data_in,
    input wire logic             rx_sfd_seen,
    input wire logic             rx_preamble_start,
    input wire logic             boot_rom_req,
    input wire logic             phy_reset_out,
    input wire logic             phy_low_power,
    input wire logic             mii_enable,
    input wire logic [2:0]       desc_fetch_words,
    input wire logic             desc_frag_count_ignore,
    input wire logic [1:0]       desc_frag_ptr_word,
    input wire logic             window_timer_start,
    input wire logic             tx_deferral_error,
    input wire logic             excessive_deferral_status,
    input wire logic [CNT_W-1:0] deferral_overrun_counter,
    input wire logic             serr_req,
    input wire logic             boot_rom_grant,
    input wire logic [31:0]      master_data_out
);
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    // Shadow of the control bits, updated on the same access edge as the register itself
    wire logic        cfg_wr  = psel & penable & pready & pwrite & (paddr == MCL_CFG_OFF);
    wire logic [2:0]  steer_w = {pwdata[10], pwdata[9] | pwdata[12], pwdata[12]};
    wire logic [31:0] swap_w  = {master_data_in[7:0], master_data_in[15:8], master_data_in[23:16],
                                 master_data_in[31:24]};
    assign cfg_d = cfg_wr ? pwdata : cfg_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cfg_q <= '0;
        else
            cfg_q <= cfg_d;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Two cycles allow for one extra flop stage between register and pin
    property p_steer; cfg_wr |-> ##2 {phy_reset_out, phy_low_power, mii_enable} == $past(steer_w, 2); endproperty
    a_steer: assert property (p_steer) else $error("phy controls differ from write");
    property p_desc; desc_fetch_words == (desc_frag_count_ignore ? MCL_DESC_WORDS_LEG : MCL_DESC_WORDS_NEW)
        && desc_frag_ptr_word == MCL_FRAG_WORD_IDX && desc_frag_count_ignore == $past(cfg_q[8]); endproperty
    a_desc: assert property (p_desc) else $error("descriptor word count wrong");
    property p_win; window_timer_start == $past(cfg_q[5] ? rx_preamble_start : rx_sfd_seen); endproperty
    a_win: assert property (p_win) else $error("window timer start wrong");
    property p_derr; tx_deferral_error == $past(excess_deferral_evt & ~cfg_q[4]); endproperty
    a_derr: assert property (p_derr) else $error("deferral error wrong");
    property p_dcnt; excess_deferral_evt && cfg_q[4] && !excessive_deferral_status
        |=> $stable(deferral_overrun_counter) && !excessive_deferral_status; endproperty
    a_dcnt: assert property (p_dcnt) else $error("deferral logged while disabled");
    property p_serr; serr_req == $past(master_parity_err & master_active & ~cfg_q[3]); endproperty
    a_serr: assert property (p_serr) else $error("system error request wrong");
    property p_grant; boot_rom_grant == $past(boot_rom_req & ~cfg_q[2]); endproperty
    a_grant: assert property (p_grant) else $error("boot rom grant wrong");
    property p_data; master_active |=> master_data_out == $past(cfg_q[0] ? swap_w : master_data_in); endproperty
    a_data: assert property (p_data) else $error("master data byte order wrong");
    cover property (cfg_wr);
    cover property (excess_deferral_evt && cfg_q[4]);
    cover property (master_active && cfg_q[0]);
endmodule // mcl_top_monitor

bind mcl_top mcl_top_monitor #(.CNT_W(CNT_W)) i_mon (.*);

/* tb/mcl_top_bench.sv */
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
module mcl_top_bench;
    import mcl_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, master_active;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, master_data_in, master_data_out, rd_q, w;
    logic        master_parity_err, excess_deferral_evt, rx_sfd_seen, rx_preamble_start, boot_rom_req;
    logic        phy_reset_out, phy_low_power, mii_enable, desc_frag_count_ignore, bus_req_conservative;
    logic        backoff_single_slot, window_timer_start, tx_deferral_error, excessive_deferral_status;
    logic        serr_req, boot_rom_enable, boot_rom_grant, err_q;
    logic [2:0]  desc_fetch_words;
    logic [1:0]  desc_frag_ptr_word;
    logic [15:0] deferral_overrun_counter;
    logic [4:0]  ev;
    int          n_mismatch = 0;
    int          comparisons = 0;

    assign {boot_rom_req, rx_preamble_start, rx_sfd_seen, excess_deferral_evt, master_parity_err} = ev;
    mcl_top #(.CNT_W(16)) i_dut (.*);

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic known;
        known = a inside {MCL_CFG_OFF, MCL_IRQ_STAT_OFF, MCL_IRQ_MASK_OFF, MCL_DEFER_CNT_OFF, MCL_STATUS_OFF};
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No local limit: only the watchdog may end a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        check("pslverr", {31'h0, pslverr}, {31'h0, !known});
        rd_q  = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        check(name, rd_q, exp);
    endtask

    task automatic fire(input logic [4:0] v);
        @(posedge pclk);
        ev <= v;
        @(posedge pclk);
        ev <= 5'h00;
        repeat (3) @(posedge pclk);
    endtask

    initial begin
        {psel, penable, pwrite, master_active, presetn} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        master_data_in = 32'h1122_3344;
        ev = 5'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check("ptr word", {30'h0, desc_frag_ptr_word}, 32'h2);
        rd(MCL_CFG_OFF, MCL_CFG_RESET, "cfg reset");
        apb(1'b1, MCL_CFG_OFF, 32'hFFFF_FFFF);
        rd(MCL_CFG_OFF, MCL_CFG_WMASK, "cfg all");
        for (int i = 0; i < 13; i++) begin
            w = 32'h1 << i;
            apb(1'b1, MCL_CFG_OFF, w);
            rd(MCL_CFG_OFF, (w & MCL_CFG_WMASK) | (32'(w[12]) << 9), "cfg bit");
            check("steer", {25'h0, phy_reset_out, phy_low_power, mii_enable, desc_frag_count_ignore,
                  bus_req_conservative, backoff_single_slot, boot_rom_enable},
                  {25'h0, w[10], w[9] | w[12], w[12], w[8], w[7], w[6], ~w[2]});
            check("fetch words", {29'h0, desc_fetch_words}, w[8] ? 32'h4 : 32'h3);
        end
        for (int j = 1; j >= 0; j--) begin
            apb(1'b1, MCL_CFG_OFF, 32'(j));
            master_active <= 1'b1;
            @(posedge pclk);
            master_active <= 1'b0;
            repeat (2) @(posedge pclk);
            check("master data", master_data_out, j ? 32'h4433_2211 : 32'h1122_3344);
        end
        master_active <= 1'b1;
        fire(5'h01);
        fire(5'h02);
        fire(5'h02);
        fire(5'h0C);
        fire(5'h10);
        rd(MCL_DEFER_CNT_OFF, 32'h2, "deferral count");
        check("deferral pin", {16'h0, deferral_overrun_counter}, 32'h2);
        check("deferral flag", {31'h0, excessive_deferral_status}, 32'h1);
        rd(MCL_IRQ_STAT_OFF, 32'h3, "event status");
        rd(MCL_STATUS_OFF, 32'h4, "status");
        check("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, MCL_IRQ_MASK_OFF, 32'h2);
        repeat (2) @(posedge pclk);
        check("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, MCL_IRQ_STAT_OFF, 32'h3);
        rd(MCL_IRQ_STAT_OFF, 32'h0, "event clear");
        check("irq cleared", {31'h0, irq}, 32'h0);
        rd(MCL_STATUS_OFF, 32'h0, "status clear");
        // Deferral, parity and boot paths all disabled, window timer on preamble
        apb(1'b1, MCL_CFG_OFF, 32'h3C);
        fire(5'h01);
        fire(5'h02);
        fire(5'h0C);
        fire(5'h10);
        rd(MCL_DEFER_CNT_OFF, 32'h2, "deferral hold");
        rd(MCL_STATUS_OFF, 32'h0, "flag hold");
        check("flag pin", {31'h0, excessive_deferral_status}, 32'h0);
        rd(8'h20, 32'h0, "unmapped data");
        check("unmapped err", {31'h0, err_q}, 32'h1);
        test_done();
    end

    initial begin
        #50us;
        n_mismatch++;
        test_done();
    end
endmodule // mcl_top_bench
